/* common/sepc_regs.svh */
`ifndef SEPC_REGS_SVH
`define SEPC_REGS_SVH

// ****************************************
// Opcodes
// ****************************************
`define SEPC_OPC_SET_LATCH 8'h06
`define SEPC_OPC_CLR_LATCH 8'h04
`define SEPC_OPC_STAT_RD 8'h05
`define SEPC_OPC_STAT_WR 8'h01
`define SEPC_OPC_ARR_RD 8'h03
`define SEPC_OPC_ARR_WR 8'h02
`define SEPC_OPC_SEC_RD 8'h83
`define SEPC_OPC_SEC_WR 8'h82

// ****************************************
// Status word fields
// ****************************************
`define SEPC_SR_BUSY 0
`define SEPC_SR_LATCH 1
`define SEPC_SR_GUARD_LO 2
`define SEPC_SR_GUARD_HI 3
`define SEPC_SR_LOCK 7
`define SEPC_SR_RESET 8'h00

// ****************************************
// Address fields and guarded regions
// ****************************************
`define SEPC_SEL_HI 10
`define SEPC_SEL_LO 9
`define SEPC_SEL_SECTOR 2'h0
`define SEPC_SEL_LOCK 2'h2
`define SEPC_GUARD_QTR 10'h300
`define SEPC_GUARD_HALF 10'h200

// ****************************************
// Frame lengths in bytes
// ****************************************
`define SEPC_LEN_CMD 3'h1
`define SEPC_LEN_STAT 3'h2
`define SEPC_LEN_ADDR 3'h3
`define SEPC_LEN_DATA 3'h4

// ****************************************
// Timing
// ****************************************
`define SEPC_CLK_NS 4
`define SEPC_TW_NS 5000000
`define SEPC_TW_CYC (`SEPC_TW_NS / `SEPC_CLK_NS)

`endif

/* common/sepc_pkg.sv */
package sepc_pkg;

  typedef enum logic [2:0] {
    ST_OPC,
    ST_ADDR,
    ST_IN,
    ST_OUT,
    ST_IGNORE
  } sepc_state_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ARRAY_WR,
    OP_SECTOR_WR,
    OP_SECTOR_LOCK,
    OP_STATUS_WR,
    OP_SET,
    OP_CLEAR
  } sepc_op_e;

  typedef enum logic [1:0] {
    SP_ARRAY,
    SP_SECTOR,
    SP_LOCKSTAT,
    SP_UID
  } sepc_space_e;

endpackage

/* logic/sepc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sepc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock_in,  // System clock
  input wire logic rst_b_in,  // Async reset, active low
  input wire logic [WIDTH-1:0] async_in,  // Pin levels
  output logic [WIDTH-1:0] sync_out  // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* logic/sepc_core.sv */
// What this block does
// - Serial input bits are sampled on rising serial clock edges.
// - Serial output changes on falling serial clock edges.
// - Clock modes 0 and 3 both work; idle level at select is free.
// - Pause starts at pause pin fall if clock low, else next fall.
// - Pause ends at pause pin rise if clock low, else next fall.
// - Paused: output floats, input and clock ignored, state kept.
// - Reset leaves the write latch cleared.
// - Writes and status writes need the write latch set first.
// - Latch clears on clear command and after every write-type cycle.
// - Busy flag at bit 0 set in write cycles; only status read allowed.
// - Busy flag returns to zero when the timed cycle ends.
// - Write latch shows at bit 1, set by the set command.
// - Two guard bits at bits 3 and 2, written by status write only.
// - Guard field 01 top quarter, 10 top half, 11 whole array.
// - Lock bit high and protect pin low freeze status writes.
// - Status word is all zero after reset.
// - Frame starts at select fall; first byte is opcode, MSB first.
// - Write frames execute only if select rises on a byte boundary.
// - Opcodes 06 set, 04 clear, 05 status read, 01 status write.
// - Opcodes 03 array read, 02 array write, 83 and 82 sector space.
// - Unique serial read when address bit 9 is one, offset bits 3..0.
// - Sector read and write need address bits 10..9 equal to 00.
// - Lock and lock status need address bits 10..9 equal to 10.
// - Array read takes a 16-bit address; only bits 9..0 count.
`timescale 1ns/1ps
`default_nettype none
`include "sepc_regs.svh"

module sepc_core #(
  parameter int WRITE_CYCLES = `SEPC_TW_CYC
) (
  input wire logic clock_in,  // System clock
  input wire logic rst_b_in,  // Async reset, active low
  input wire logic spi_clk_in,  // Serial clock pin
  input wire logic sel_b_in,  // Device select pin, active low
  input wire logic serial_in,  // Serial data pin
  input wire logic pause_b_in,  // Pause pin, active low
  input wire logic protect_b_in,  // Protect pin, active low
  output logic serial_out,  // Serial data out level
  output logic serial_oe_b_out,  // Output enable, low drives
  output logic [9:0] mem_addr_out,  // Storage address
  output sepc_pkg::sepc_space_e mem_space_out,  // Storage space
  input wire logic [7:0] mem_rdata_in,  // Storage read data
  input wire logic sector_locked_in,  // Sector already locked
  output logic wbyte_valid_out,  // Write byte pulse
  output logic [9:0] wbyte_addr_out,  // Write byte address
  output logic [7:0] wbyte_data_out,  // Write byte data
  output logic commit_out,  // Commit pulse
  output sepc_pkg::sepc_op_e commit_op_out,  // Committed operation
  output logic discard_out,  // Write frame dropped pulse
  output logic [7:0] status_out  // Status word
);
  import sepc_pkg::*;

  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  logic clk_s, sel_b_s, din_s, pause_b_s, protect_b_s;
  logic clk_d, sel_b_d, paused_r;
  logic rise, fall, frame_end, sel;

  sepc_sync #(.WIDTH(5), .RESET_VAL(5'h0b)) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in({spi_clk_in, sel_b_in, serial_in, pause_b_in,
               protect_b_in}),
    .sync_out({clk_s, sel_b_s, din_s, pause_b_s, protect_b_s})
  );

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_d <= 1'b0;
      sel_b_d <= 1'b1;
    end else begin
      clk_d <= clk_s;
      sel_b_d <= sel_b_s;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      paused_r <= 1'b0;
    end else if (sel_b_s) begin
      paused_r <= 1'b0;
    end else if (!clk_s) begin
      paused_r <= ~pause_b_s;
    end
  end

  assign sel = ~sel_b_s;
  assign rise = sel & ~paused_r & clk_s & ~clk_d;
  assign fall = sel & ~paused_r & ~clk_s & clk_d;
  assign frame_end = sel_b_s & ~sel_b_d;

  // ****************************************
  // Status word and decode helpers
  // ****************************************
  logic busy_r, latch_r, lock_r;
  logic [1:0] guard_r;
  logic hw_frozen;
  logic [7:0] status;

  assign hw_frozen = lock_r & ~protect_b_s;

  always_comb begin
    status = `SEPC_SR_RESET;
    status[`SEPC_SR_BUSY] = busy_r;
    status[`SEPC_SR_LATCH] = latch_r;
    status[`SEPC_SR_GUARD_LO] = guard_r[0];
    status[`SEPC_SR_GUARD_HI] = guard_r[1];
    status[`SEPC_SR_LOCK] = lock_r;
  end

  function automatic logic guarded(input logic [9:0] a,
                                   input logic [1:0] g);
    unique case (g)
      2'h0: guarded = 1'b0;
      2'h1: guarded = (a >= `SEPC_GUARD_QTR);
      2'h2: guarded = (a >= `SEPC_GUARD_HALF);
      2'h3: guarded = 1'b1;
    endcase
  endfunction

  function automatic sepc_state_e decode(input logic [7:0] opc);
    decode = ST_IGNORE;
    if (opc == `SEPC_OPC_STAT_RD) begin
      decode = ST_OUT;
    end else if (!busy_r) begin
      unique case (opc)
        `SEPC_OPC_SET_LATCH, `SEPC_OPC_CLR_LATCH: decode = ST_IN;
        `SEPC_OPC_STAT_WR:
          decode = (latch_r && !hw_frozen) ? ST_IN : ST_IGNORE;
        `SEPC_OPC_ARR_RD, `SEPC_OPC_SEC_RD: decode = ST_ADDR;
        `SEPC_OPC_ARR_WR, `SEPC_OPC_SEC_WR:
          decode = latch_r ? ST_ADDR : ST_IGNORE;
        default: decode = ST_IGNORE;
      endcase
    end
  endfunction

  function automatic logic is_read(input logic [7:0] opc);
    is_read = (opc == `SEPC_OPC_ARR_RD) || (opc == `SEPC_OPC_SEC_RD);
  endfunction

  // ****************************************
  // Frame engine
  // ****************************************
  sepc_state_e state_r;
  logic [7:0] opc_r, shift_r, byte_v, stat_data_r;
  logic [2:0] bit_r, nbyte_r, obit_r;
  logic [15:0] addr_r;
  logic reject_r;

  assign byte_v = {shift_r[6:0], din_s};

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_OPC;
      opc_r <= 8'h00;
      shift_r <= 8'h00;
      stat_data_r <= 8'h00;
      bit_r <= 3'h0;
      nbyte_r <= 3'h0;
      addr_r <= 16'h0000;
      reject_r <= 1'b0;
    end else if (!sel) begin
      state_r <= ST_OPC;
      bit_r <= 3'h0;
      nbyte_r <= 3'h0;
      reject_r <= 1'b0;
    end else if (rise) begin
      shift_r <= byte_v;
      bit_r <= bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        if (nbyte_r != 3'h7) begin
          nbyte_r <= nbyte_r + 3'h1;
        end
        unique case (state_r)
          ST_OPC: begin
            opc_r <= byte_v;
            state_r <= decode(byte_v);
          end
          ST_ADDR: begin
            addr_r <= {addr_r[7:0], byte_v};
            if (nbyte_r == 3'h2) begin
              state_r <= is_read(opc_r) ? ST_OUT : ST_IN;
            end
          end
          ST_IN: begin
            if (opc_r == `SEPC_OPC_STAT_WR && nbyte_r == 3'h1) begin
              stat_data_r <= byte_v;
            end
            if (opc_r == `SEPC_OPC_ARR_WR) begin
              if (guarded(addr_r[9:0], guard_r)) begin
                reject_r <= 1'b1;
              end
              addr_r[4:0] <= addr_r[4:0] + 5'h01;
            end
            if (opc_r == `SEPC_OPC_SEC_WR) begin
              addr_r[4:0] <= addr_r[4:0] + 5'h01;
            end
          end
          ST_OUT, ST_IGNORE: begin
          end
        endcase
      end
    end else if (fall && state_r == ST_OUT && obit_r == 3'h0 &&
                 opc_r != `SEPC_OPC_STAT_RD) begin
      addr_r <= addr_r + 16'h0001;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_space_out <= SP_ARRAY;
      mem_addr_out <= 10'h000;
    end else begin
      mem_addr_out <= addr_r[9:0];
      if (opc_r[7] == 1'b0) begin
        mem_space_out <= SP_ARRAY;
      end else if (addr_r[`SEPC_SEL_LO]) begin
        mem_space_out <= SP_UID;
      end else if (addr_r[`SEPC_SEL_HI]) begin
        mem_space_out <= SP_LOCKSTAT;
      end else begin
        mem_space_out <= SP_SECTOR;
      end
    end
  end

  // Streamed write bytes; an outside page buffer holds them
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wbyte_valid_out <= 1'b0;
      wbyte_addr_out <= 10'h000;
      wbyte_data_out <= 8'h00;
    end else begin
      wbyte_valid_out <= rise && bit_r == 3'h7 && state_r == ST_IN &&
                         (opc_r == `SEPC_OPC_ARR_WR ||
                          opc_r == `SEPC_OPC_SEC_WR);
      if (rise && bit_r == 3'h7) begin
        wbyte_addr_out <= addr_r[9:0];
        wbyte_data_out <= byte_v;
      end
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic [7:0] osh_r, src;

  assign src = (opc_r == `SEPC_OPC_STAT_RD) ? status : mem_rdata_in;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_out <= 1'b0;
      osh_r <= 8'h00;
      obit_r <= 3'h0;
    end else if (!sel) begin
      obit_r <= 3'h0;
    end else if (fall && state_r == ST_OUT) begin
      obit_r <= obit_r + 3'h1;
      if (obit_r == 3'h0) begin
        serial_out <= src[7];
        osh_r <= {src[6:0], 1'b0};
      end else begin
        serial_out <= osh_r[7];
        osh_r <= {osh_r[6:0], 1'b0};
      end
    end
  end

  assign serial_oe_b_out = ~(sel & ~paused_r & state_r == ST_OUT);

  // ****************************************
  // Frame completion
  // ****************************************
  sepc_op_e end_op;
  logic boundary, wr_frame;

  assign boundary = (bit_r == 3'h0);
  assign wr_frame = (state_r == ST_IN || state_r == ST_ADDR) &&
                    !is_read(opc_r);

  always_comb begin
    end_op = OP_NONE;
    if (state_r == ST_IN && boundary) begin
      unique case (opc_r)
        `SEPC_OPC_SET_LATCH: end_op = OP_SET;
        `SEPC_OPC_CLR_LATCH: end_op = OP_CLEAR;
        `SEPC_OPC_STAT_WR:
          if (nbyte_r >= `SEPC_LEN_STAT) end_op = OP_STATUS_WR;
        `SEPC_OPC_ARR_WR:
          if (nbyte_r >= `SEPC_LEN_DATA && !reject_r)
            end_op = OP_ARRAY_WR;
        `SEPC_OPC_SEC_WR: begin
          if (addr_r[`SEPC_SEL_HI:`SEPC_SEL_LO] == `SEPC_SEL_LOCK &&
              nbyte_r >= `SEPC_LEN_ADDR) begin
            end_op = OP_SECTOR_LOCK;
          end else if (addr_r[`SEPC_SEL_HI:`SEPC_SEL_LO] ==
                       `SEPC_SEL_SECTOR && nbyte_r >= `SEPC_LEN_DATA &&
                       !sector_locked_in) begin
            end_op = OP_SECTOR_WR;
          end
        end
        default: end_op = OP_NONE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      commit_out <= 1'b0;
      commit_op_out <= OP_NONE;
      discard_out <= 1'b0;
    end else begin
      commit_out <= frame_end && end_op != OP_NONE &&
                    end_op != OP_SET && end_op != OP_CLEAR;
      discard_out <= frame_end && wr_frame && end_op == OP_NONE;
      if (frame_end) begin
        commit_op_out <= end_op;
      end
    end
  end

  // ****************************************
  // Timed cycle, latch and status bits
  // ****************************************
  logic [CW-1:0] cnt_r;
  logic pend_stat_r, long_op;

  assign long_op = frame_end && end_op != OP_NONE &&
                   end_op != OP_SET && end_op != OP_CLEAR;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      pend_stat_r <= 1'b0;
    end else if (long_op) begin
      busy_r <= 1'b1;
      cnt_r <= CW'(WRITE_CYCLES - 1);
      pend_stat_r <= (end_op == OP_STATUS_WR);
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_r <= 1'b0;
        pend_stat_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_r <= 1'b0;
    end else if (frame_end && end_op == OP_SET) begin
      latch_r <= 1'b1;
    end else if (frame_end && end_op == OP_CLEAR) begin
      latch_r <= 1'b0;
    end else if (busy_r && cnt_r == '0) begin
      latch_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      guard_r <= 2'h0;
      lock_r <= 1'b0;
    end else if (busy_r && cnt_r == '0 && pend_stat_r) begin
      guard_r <= {stat_data_r[`SEPC_SR_GUARD_HI],
                  stat_data_r[`SEPC_SR_GUARD_LO]};
      lock_r <= stat_data_r[`SEPC_SR_LOCK];
    end
  end

  assign status_out = status;

endmodule

`default_nettype wire

/* tb/sepc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sepc_assertions #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clock_in,  // System clock
  input wire logic rst_b_in,  // Async reset, active low
  input wire logic spi_clk_in,  // Serial clock pin
  input wire logic sel_b_in,  // Select pin, active low
  input wire logic pause_b_in,  // Pause pin, active low
  input wire logic serial_out,  // Serial data out
  input wire logic serial_oe_b_out,  // Output enable, low drives
  input wire logic wbyte_valid_out,  // Write byte pulse
  input wire logic commit_out,  // Commit pulse
  input wire logic discard_out,  // Dropped frame pulse
  input wire logic [7:0] status_out  // Status word
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  int busy_len_r;
  // ****************************************
  // Length of the current busy stretch
  // ****************************************
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_len_r <= 0;
    end else if (status_out[0]) begin
      busy_len_r <= busy_len_r + 1;
    end else begin
      busy_len_r <= 0;
    end
  end
  a_reset_clean: assert property (
    $rose(rst_b_in) |-> status_out == 8'h00)
    else $error("status word not clear after reset");
  a_idle_float: assert property (
    sel_b_in [*5] |-> serial_oe_b_out)
    else $error("output driven while deselected");
  a_pause_float: assert property (
    (!pause_b_in && !spi_clk_in) [*6] |-> serial_oe_b_out)
    else $error("output driven during pause");
  a_out_on_fall: assert property (
    (spi_clk_in && !sel_b_in) [*3] |-> $stable(serial_out))
    else $error("serial output moved while clock high");
  a_busy_length: assert property (
    $fell(status_out[0]) |-> busy_len_r == WRITE_CYCLES)
    else $error("busy stretch has wrong length");
  a_latch_cleared: assert property (
    $fell(status_out[0]) |-> !status_out[1])
    else $error("write latch still set after timed cycle");
  a_commit_busy: assert property (
    commit_out |=> status_out[0])
    else $error("busy not raised after commit");
  a_commit_latch: assert property (
    commit_out |-> status_out[1] && !discard_out ##1 !commit_out)
    else $error("commit without latch or not a single pulse");
  a_busy_quiet: assert property (
    status_out[0] && $past(status_out[0]) |->
      !wbyte_valid_out && !commit_out)
    else $error("write activity while busy");
  a_guard_timing: assert property (
    $changed({status_out[7], status_out[3:2]}) |-> $fell(status_out[0]))
    else $error("guard or lock bits changed outside cycle end");
  a_latch_rise: assert property (
    $rose(status_out[1]) |-> !status_out[0])
    else $error("write latch set while busy");
endmodule
bind sepc_core sepc_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .spi_clk_in(spi_clk_in),
  .sel_b_in(sel_b_in), .pause_b_in(pause_b_in), .serial_out(serial_out),
  .serial_oe_b_out(serial_oe_b_out), .wbyte_valid_out(wbyte_valid_out),
  .commit_out(commit_out), .discard_out(discard_out),
  .status_out(status_out));
`default_nettype wire

/* tb/sepc_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sepc_master (
  output logic spi_clk_out,  // Serial clock to device
  output logic sel_b_out,  // Device select, active low
  output logic mosi_out,  // Data to device
  output logic pause_b_out,  // Pause, active low
  input wire logic miso_in,  // Data from device
  input wire logic oe_b_in  // Device drive enable, low drives
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic mode3 = 1'b0;
  logic oe_in_pause = 1'b0;
  initial begin
    spi_clk_out = 1'b0;
    sel_b_out = 1'b1;
    mosi_out = 1'b0;
    pause_b_out = 1'b1;
  end
  task automatic hold();
    // pause taken with clock low, select kept low
    pause_b_out = 1'b0;
    #40;
    oe_in_pause = oe_b_in;
    repeat (3) begin
      mosi_out = ~mosi_out;
      spi_clk_out = 1'b1;
      #20;
      spi_clk_out = 1'b0;
      #20;
    end
    pause_b_out = 1'b1;
    #40;
  endtask
  task automatic frame(input int nbits, input int pause_at);
    logic [7:0] b;
    logic [7:0] r;
    rx_q.delete();
    // idle level of the mode at select fall
    spi_clk_out = mode3;
    #40;
    sel_b_out = 1'b0;
    #40;
    // bits MSB first, read late in the high phase
    for (int i = 0; i < nbits; i++) begin
      if (i % 8 == 0) b = tx_q.size() > 0 ? tx_q.pop_front() : 8'h00;
      spi_clk_out = 1'b0;
      mosi_out = b[7 - i % 8];
      #16;
      if (i == pause_at) hold();
      spi_clk_out = 1'b1;
      #15;
      // Undriven line reads as the inverse of its last level
      r = {r[6:0], oe_b_in ? ~miso_in : miso_in};
      if (i % 8 == 7) rx_q.push_back(r);
      #1;
    end
    spi_clk_out = mode3;
    #16;
    sel_b_out = 1'b1;
    // Released line must not keep the last value
    mosi_out = ~mosi_out;
    #40;
  endtask
endmodule
`default_nettype wire

/* tb/tb_spi_eeprom_cmd_protect.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sepc_regs.svh"
module tb_spi_eeprom_cmd_protect;
  import sepc_pkg::*;
  localparam int WCYC = 400;
  logic clock_in, rst_b_in, spi_clk, sel_b, mosi, pause_b, prot_b, locked;
  logic sout, oe_b, wbv, commit, discard;
  logic [9:0] maddr, wba;
  logic [7:0] wbd, status;
  sepc_space_e space;
  sepc_op_e cop, last_op;
  int mismatches, compares, cycles, n_com, n_dis;
  int latch_m, busy_m, guard_m, lock_m;
  logic [17:0] wq[$];
  logic [23:0] rtab[4] = '{24'h03fc1e, 24'h830011, 24'h830407, 24'h830203};
  logic [7:0] rmask[4] = '{8'hff, 8'hff, 8'hc0, 8'hcf};
  wire logic [7:0] rdata = {space, 1'b0, maddr[4:0]};
  sepc_master u_m (.spi_clk_out(spi_clk), .sel_b_out(sel_b),
    .mosi_out(mosi), .pause_b_out(pause_b), .miso_in(sout), .oe_b_in(oe_b));
  sepc_core #(.WRITE_CYCLES(WCYC)) u_dut (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .spi_clk_in(spi_clk), .sel_b_in(sel_b),
    .serial_in(mosi), .pause_b_in(pause_b), .protect_b_in(prot_b),
    .serial_out(sout), .serial_oe_b_out(oe_b), .mem_addr_out(maddr),
    .mem_space_out(space), .mem_rdata_in(rdata), .sector_locked_in(locked),
    .wbyte_valid_out(wbv), .wbyte_addr_out(wba), .wbyte_data_out(wbd),
    .commit_out(commit), .commit_op_out(cop), .discard_out(discard),
    .status_out(status));
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (commit === 1'b1) last_op = cop;
    if (commit === 1'b1) n_com++;
    if (discard === 1'b1) n_dis++;
    if (wbv === 1'b1) wq.push_back({wba, wbd});
    if (cycles == 60000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [7:0] sw();
    return {lock_m[0], 3'b000, guard_m[1:0], latch_m[0], busy_m[0]};
  endfunction
  task automatic send(input logic [7:0] b[$], input int nb, input int pa);
    @(posedge clock_in);
    #1;
    u_m.tx_q = b;
    u_m.frame(nb, pa);
    repeat (12) @(posedge clock_in);
  endtask
  task automatic status_read_cmd(input int pa);
    send('{`SEPC_OPC_STAT_RD, 8'h00, 8'h00}, 24, pa);
    chk("status read 1", sw(), u_m.rx_q[1]);
    chk("status read 2", sw(), u_m.rx_q[2]);
  endtask
  task automatic wr(input logic [7:0] b[$], input int en, ok, sepc_op_e op);
    int c0;
    if (en) send('{`SEPC_OPC_SET_LATCH}, 8, -1);
    latch_m = en;
    c0 = n_com;
    send(b, 8 * b.size(), -1);
    chk("commit count", ok, n_com - c0);
    if (ok) begin
      chk("commit op", op, last_op);
      busy_m = 1;
      send('{`SEPC_OPC_CLR_LATCH}, 8, -1);
      status_read_cmd(-1);
      for (int i = 0; i < WCYC + 50 && status[0] !== 1'b0; i++) begin
        @(posedge clock_in);
        #1;
      end
      busy_m = 0;
      latch_m = 0;
      if (op == OP_STATUS_WR) guard_m = b[1][3:2];
      if (op == OP_STATUS_WR) lock_m = b[1][7];
    end else if (en) begin
      send('{`SEPC_OPC_CLR_LATCH}, 8, -1);
      latch_m = 0;
    end
    chk("status word", sw(), status);
  endtask
  initial begin
    int a, lo, c0, d0;
    rst_b_in = 1'b0;
    prot_b = 1'b1;
    locked = 1'b0;
    void'($urandom(32'h99a5));
    repeat (8) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    repeat (4) @(posedge clock_in);
    chk("status after reset", 0, status);
    status_read_cmd(-1);
    u_m.mode3 = 1'b1;
    send('{`SEPC_OPC_SET_LATCH}, 8, -1);
    latch_m = 1;
    chk("latch set", sw(), status);
    status_read_cmd(-1);
    u_m.mode3 = 1'b0;
    status_read_cmd(12);
    chk("float in pause", 1, u_m.oe_in_pause);
    send('{`SEPC_OPC_CLR_LATCH}, 8, -1);
    latch_m = 0;
    chk("latch clear", sw(), status);
    wr('{`SEPC_OPC_ARR_WR, 8'h00, 8'h10, 8'h5a}, 0, 0, OP_NONE);
    send('{`SEPC_OPC_SET_LATCH}, 8, -1);
    c0 = n_com;
    d0 = n_dis;
    send('{`SEPC_OPC_ARR_WR, 8'h00, 8'h10, 8'h5a}, 33, -1);
    chk("discard count", d0 + 1, n_dis);
    chk("no commit", c0, n_com);
    wr('{`SEPC_OPC_CLR_LATCH}, 0, 0, OP_NONE);
    a = $urandom_range(0, 1023);
    lo = $urandom_range(0, 255);
    wq.delete();
    wr('{`SEPC_OPC_ARR_WR, 8'hfc | 8'(a >> 8), 8'(a), 8'(lo)}, 1, 1,
       OP_ARRAY_WR);
    chk("write byte", {a[9:0], lo[7:0]}, wq.size() ? wq[0] : 18'h0);
    for (int g = 0; g < 4; g++) begin
      wr('{`SEPC_OPC_STAT_WR, 8'h73 | 8'(g << 2)}, 1, 1, OP_STATUS_WR);
      lo = g == 0 ? 1024 : g == 1 ? 768 : g == 2 ? 512 : 0;
      for (int k = 0; k < 2; k++) begin
        a = k == 0 ? (lo + 1023) % 1024 : $urandom_range(lo % 1024, 1023);
        wr('{`SEPC_OPC_ARR_WR, 8'(a >> 8), 8'(a), 8'h3c}, 1, int'(a < lo),
           OP_ARRAY_WR);
      end
    end
    wr('{`SEPC_OPC_STAT_WR, 8'h80}, 1, 1, OP_STATUS_WR);
    #1 prot_b = 1'b0;
    wr('{`SEPC_OPC_STAT_WR, 8'h0c}, 1, 0, OP_NONE);
    #1 prot_b = 1'b1;
    wr('{`SEPC_OPC_STAT_WR, 8'h00}, 1, 1, OP_STATUS_WR);
    wr('{`SEPC_OPC_SEC_WR, 8'h00, 8'h05, 8'ha5}, 1, 1, OP_SECTOR_WR);
    #1 locked = 1'b1;
    wr('{`SEPC_OPC_SEC_WR, 8'h00, 8'h05, 8'ha5}, 1, 0, OP_NONE);
    #1 locked = 1'b0;
    wr('{`SEPC_OPC_SEC_WR, 8'h04, 8'h00}, 1, 1, OP_SECTOR_LOCK);
    for (int r = 0; r < 4; r++) begin
      send('{rtab[r][23:16], rtab[r][15:8], rtab[r][7:0], 8'h00, 8'h00},
           40, -1);
      for (int i = 0; i < 2; i++)
        chk("read byte", {r[1:0], 1'b0, 5'(rtab[r][4:0] + i)} & rmask[r],
            u_m.rx_q[3 + i] & rmask[r]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
